//--- core/bppr_backup_store.sv
// three backup bytes, cleared by the full reset only
`timescale 1ns/1ps
`include "bppr_regs.svh"
module bppr_backup_store
(
    // clock and full-domain reset
    input  wire logic    clk,
    input  wire logic    rst_full,
    // bank side
    bppr_store_if.store  port
);

    logic [7:0] mem      [`BPPR_BACKUP_DEPTH];
    logic [7:0] next_mem [`BPPR_BACKUP_DEPTH];
    logic [7:0] rd_q;
    logic [7:0] next_rd_q;

    genvar g;
    generate
        for (g = 0; g < `BPPR_BACKUP_DEPTH; g++)
        begin : gen_byte
            always_comb
            begin
                next_mem[g] = mem[g];
                if (port.wr_en && port.wr_idx == 2'(g))
                begin
                    next_mem[g] = port.wr_data;
                end
            end

            // no other reset touches these bytes
            always_ff @(posedge clk)
            begin
                if (rst_full)
                begin
                    mem[g] <= `BPPR_RST_BACKUP;
                end
                else
                begin
                    mem[g] <= next_mem[g];
                end
            end
        end
    endgenerate

    always_comb
    begin
        next_rd_q = 8'h00;
        if (port.rd_idx < 2'(`BPPR_BACKUP_DEPTH))
        begin
            next_rd_q = mem[port.rd_idx];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_full)
        begin
            rd_q <= 8'h00;
        end
        else
        begin
            rd_q <= next_rd_q;
        end
    end

    assign port.rd_data = rd_q;

endmodule

//--- core/bppr_bank.sv
// backup storage, pad pull control and reference state register bank
// Behaviour
// - three read/write backup bytes at 0x19..0x1b, reset to zero.
// - backup bytes keep contents while the rtc supply stays on.
// - only the full reset clears the backup bytes.
// - pad pull control at 0x1c returns to default on general reset.
// - bit 6 enables control bus data and clock pull-ups; resets 0.
// - bit 5 enables scaling bus data and clock pull-ups; resets 0.
// - bit 4 enables power-on pad pull-up; resets 1.
// - bit 3 enables sleep pad pull-down; resets 1.
// - bit 2 enables power-hold pad pull-down; resets 1.
// - bit 1 enables cold reset pad pull-down; resets 1.
// - bit 0 enables secondary reset output pull-down; resets 1.
// - reference state at 0x1d returns to default on turn-off reset.
// - state 00 off, 01 active, 10 reserved, 11 sleep; resets 01.
// - reference state is read-only except in test mode.
`timescale 1ns/1ps
`include "bppr_regs.svh"
module bppr_bank
(
    // clock and the three reset domains, all synchronous active high
    input  wire logic       CLK_SYS,
    input  wire logic       RST,
    input  wire logic       RST_GENERAL,
    input  wire logic       RST_TURNOFF,
    // test mode strap, from a pin
    input  wire logic       TEST_MODE,
    // register access port, same clock domain
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    output logic            REG_RVALID,
    // pad pull controls
    output logic            CONTROL_BUS_PULLUP_EN,
    output logic            SCALING_BUS_PULLUP_EN,
    output logic            POWER_BUTTON_PULLUP_EN,
    output logic            SLEEP_PIN_PULLDOWN_EN,
    output logic            HOLD_PIN_PULLDOWN_EN,
    output logic            COLD_RESET_PULLDOWN_EN,
    output logic            AUX_RESET_OUT_PULLDOWN_EN,
    // reference state
    output bppr_pkg::bppr_ref_type REFERENCE_STATE_FIELD
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic [2:0] decode(input logic [7:0] addr);
        logic [2:0] sel;
        sel = 3'h7;
        if (addr == `BPPR_OFF_BACKUP_THREE)
        begin
            sel = 3'h0;
        end
        else if (addr == `BPPR_OFF_BACKUP_FOUR)
        begin
            sel = 3'h1;
        end
        else if (addr == `BPPR_OFF_BACKUP_FIVE)
        begin
            sel = 3'h2;
        end
        else if (addr == `BPPR_OFF_PAD_PULL)
        begin
            sel = 3'h3;
        end
        else if (addr == `BPPR_OFF_REF_STATE)
        begin
            sel = 3'h4;
        end
        return sel;
    endfunction

    logic [2:0] wr_sel;
    logic [2:0] rd_sel;

    assign wr_sel = decode(REG_ADDR);
    assign rd_sel = decode(REG_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // test mode strap synchroniser

    logic test_meta;
    logic test_sync;

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            test_meta <= 1'b0;
            test_sync <= 1'b0;
        end
        else
        begin
            test_meta <= TEST_MODE;
            test_sync <= test_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // backup bytes

    bppr_store_if store_bus ();

    assign store_bus.wr_en   = REG_WR && wr_sel <= 3'h2;
    assign store_bus.wr_idx  = wr_sel[1:0];
    assign store_bus.wr_data = REG_WDATA;
    assign store_bus.rd_idx  = rd_sel[1:0];

    // full reset only: general and turn-off resets leave the bytes alone
    bppr_backup_store u_store
    (
        .clk      (CLK_SYS),
        .rst_full (RST),
        .port     (store_bus.store)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pad pull control, general reset domain

    localparam logic [7:0] pad_rst = `BPPR_RST_PAD_PULL;

    logic [7:0] pad_pull;
    logic [7:0] next_pad_pull;

    always_comb
    begin
        next_pad_pull = pad_pull;
        if (REG_WR && wr_sel == 3'h3)
        begin
            next_pad_pull = REG_WDATA & `BPPR_MASK_PAD_PULL;
        end
    end

    // the full reset also implies a general reset
    always_ff @(posedge CLK_SYS)
    begin
        if (RST || RST_GENERAL)
        begin
            pad_pull <= `BPPR_RST_PAD_PULL;
        end
        else
        begin
            pad_pull <= next_pad_pull;
        end
    end

    // pad enables mirror the register, so they change at the same edge as the write
    always_ff @(posedge CLK_SYS)
    begin
        if (RST || RST_GENERAL)
        begin
            CONTROL_BUS_PULLUP_EN     <= pad_rst[`BPPR_BIT_CTL_BUS_PU];
            SCALING_BUS_PULLUP_EN     <= pad_rst[`BPPR_BIT_SCL_BUS_PU];
            POWER_BUTTON_PULLUP_EN    <= pad_rst[`BPPR_BIT_PWR_BTN_PU];
            SLEEP_PIN_PULLDOWN_EN     <= pad_rst[`BPPR_BIT_SLEEP_PD];
            HOLD_PIN_PULLDOWN_EN      <= pad_rst[`BPPR_BIT_HOLD_PD];
            COLD_RESET_PULLDOWN_EN    <= pad_rst[`BPPR_BIT_COLD_RST_PD];
            AUX_RESET_OUT_PULLDOWN_EN <= pad_rst[`BPPR_BIT_AUX_RST_PD];
        end
        else
        begin
            CONTROL_BUS_PULLUP_EN     <= next_pad_pull[`BPPR_BIT_CTL_BUS_PU];
            SCALING_BUS_PULLUP_EN     <= next_pad_pull[`BPPR_BIT_SCL_BUS_PU];
            POWER_BUTTON_PULLUP_EN    <= next_pad_pull[`BPPR_BIT_PWR_BTN_PU];
            SLEEP_PIN_PULLDOWN_EN     <= next_pad_pull[`BPPR_BIT_SLEEP_PD];
            HOLD_PIN_PULLDOWN_EN      <= next_pad_pull[`BPPR_BIT_HOLD_PD];
            COLD_RESET_PULLDOWN_EN    <= next_pad_pull[`BPPR_BIT_COLD_RST_PD];
            AUX_RESET_OUT_PULLDOWN_EN <= next_pad_pull[`BPPR_BIT_AUX_RST_PD];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // reference state, turn-off reset domain

    bppr_pkg::bppr_ref_type ref_state;
    bppr_pkg::bppr_ref_type next_ref_state;

    always_comb
    begin
        next_ref_state = ref_state;
        // ignored outside test mode, no error shown
        if (REG_WR && wr_sel == 3'h4 && test_sync)
        begin
            next_ref_state = bppr_pkg::bppr_ref_type'(REG_WDATA[1:0]);
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST || RST_TURNOFF)
        begin
            ref_state             <= bppr_pkg::bppr_ref_type'(2'(`BPPR_RST_REF_STATE));
            REFERENCE_STATE_FIELD <= bppr_pkg::bppr_ref_type'(2'(`BPPR_RST_REF_STATE));
        end
        else
        begin
            ref_state             <= next_ref_state;
            REFERENCE_STATE_FIELD <= next_ref_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path: two cycles, aligned with the store's registered read data

    logic       rd_pend;
    logic [2:0] rd_sel_q;
    logic [7:0] rd_local;
    logic [7:0] next_rdata;

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            rd_pend  <= 1'b0;
            rd_sel_q <= 3'h7;
            rd_local <= 8'h00;
        end
        else
        begin
            rd_pend  <= REG_RD;
            rd_sel_q <= rd_sel;
            if (rd_sel == 3'h3)
            begin
                rd_local <= pad_pull & `BPPR_MASK_PAD_PULL;
            end
            else if (rd_sel == 3'h4)
            begin
                rd_local <= {6'h00, ref_state};
            end
            else
            begin
                rd_local <= 8'h00;
            end
        end
    end

    always_comb
    begin
        next_rdata = 8'h00;
        if (rd_sel_q <= 3'h2)
        begin
            next_rdata = store_bus.rd_data;
        end
        else
        begin
            next_rdata = rd_local;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            REG_RDATA  <= 8'h00;
            REG_RVALID <= 1'b0;
        end
        else
        begin
            REG_RDATA  <= rd_pend ? next_rdata : 8'h00;
            REG_RVALID <= rd_pend;
        end
    end

endmodule

//--- core/bppr_pkg.sv
// types shared by the backup and pad pull bank
package bppr_pkg;

    typedef enum logic [1:0]
    {
        REF_OFF      = 2'h0,
        REF_ACTIVE   = 2'h1,
        REF_RESERVED = 2'h2,
        REF_SLEEP    = 2'h3
    } bppr_ref_type;

endpackage

//--- core/bppr_regs.svh
// register offsets, field positions and reset values of the backup and pad pull bank
`ifndef BPPR_REGS_SVH
`define BPPR_REGS_SVH

`define BPPR_OFF_BACKUP_THREE   8'h19
`define BPPR_OFF_BACKUP_FOUR    8'h1a
`define BPPR_OFF_BACKUP_FIVE    8'h1b
`define BPPR_OFF_PAD_PULL       8'h1c
`define BPPR_OFF_REF_STATE      8'h1d

`define BPPR_RST_BACKUP         8'h00
`define BPPR_RST_PAD_PULL       8'h1f
`define BPPR_RST_REF_STATE      8'h01

`define BPPR_MASK_PAD_PULL      8'h7f
`define BPPR_MASK_REF_STATE     8'h03

`define BPPR_BIT_CTL_BUS_PU     6
`define BPPR_BIT_SCL_BUS_PU     5
`define BPPR_BIT_PWR_BTN_PU     4
`define BPPR_BIT_SLEEP_PD       3
`define BPPR_BIT_HOLD_PD        2
`define BPPR_BIT_COLD_RST_PD    1
`define BPPR_BIT_AUX_RST_PD     0

`define BPPR_BACKUP_DEPTH       3

`endif

//--- core/bppr_store_if.sv
// carrier between the bank and its backup byte store
`timescale 1ns/1ps
interface bppr_store_if;
    logic       wr_en;
    logic [1:0] wr_idx;
    logic [7:0] wr_data;
    logic [1:0] rd_idx;
    logic [7:0] rd_data;

    modport bank
    (
        output wr_en,
        output wr_idx,
        output wr_data,
        output rd_idx,
        input  rd_data
    );
    modport store
    (
        input  wr_en,
        input  wr_idx,
        input  wr_data,
        input  rd_idx,
        output rd_data
    );
endinterface

//--- sim/bppr_bank_assertions.sv
// port-level checks of the backup and pad pull bank
`timescale 1ns/1ps
module bppr_bank_assertions
(
    // clock, resets and test strap
    input wire logic       CLK_SYS, RST, RST_GENERAL, RST_TURNOFF, TEST_MODE,
    // register access
    input wire logic       REG_WR, REG_RD, REG_RVALID,
    input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
    // pad pull controls and reference state
    input wire logic       CONTROL_BUS_PULLUP_EN, SCALING_BUS_PULLUP_EN, POWER_BUTTON_PULLUP_EN,
    input wire logic       SLEEP_PIN_PULLDOWN_EN, HOLD_PIN_PULLDOWN_EN, COLD_RESET_PULLDOWN_EN,
    input wire logic       AUX_RESET_OUT_PULLDOWN_EN,
    input wire bppr_pkg::bppr_ref_type REFERENCE_STATE_FIELD
);
    wire logic [7:0] pad = {1'b0, CONTROL_BUS_PULLUP_EN, SCALING_BUS_PULLUP_EN,
        POWER_BUTTON_PULLUP_EN, SLEEP_PIN_PULLDOWN_EN, HOLD_PIN_PULLDOWN_EN,
        COLD_RESET_PULLDOWN_EN, AUX_RESET_OUT_PULLDOWN_EN};
    wire logic [7:0] ref8 = {6'h00, REFERENCE_STATE_FIELD};
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // strap history covers the two-flop synchroniser
    sequence locked; !TEST_MODE [*3] ##0 !RST_TURNOFF; endsequence
    sequence unlocked; TEST_MODE [*3]; endsequence
    sequence ref_wr; REG_WR && REG_ADDR == 8'h1d && !RST_TURNOFF; endsequence
    sequence test_wr; unlocked ##0 ref_wr; endsequence
    sequence unmapped_rd; REG_RD && (REG_ADDR < 8'h19 || REG_ADDR > 8'h1d); endsequence
    sequence pad_wr; REG_WR && REG_ADDR == 8'h1c && !RST_GENERAL; endsequence
    a_read_latency: assert property (REG_RD |-> ##2 REG_RVALID) else $error("late rvalid");
    a_rdata_quiet: assert property (!REG_RVALID |-> REG_RDATA == 8'h00) else $error("rdata");
    a_unmapped_zero: assert property (unmapped_rd |-> ##2 REG_RDATA == 8'h00)
        else $error("unmapped read");
    a_pad_write: assert property (pad_wr |=> pad == ($past(REG_WDATA) & 8'h7f))
        else $error("pad write");
    a_gen_default: assert property (RST_GENERAL |=> pad == 8'h1f) else $error("pad reset");
    a_turnoff_ref: assert property (RST_TURNOFF |=> ref8 == 8'h01) else $error("ref reset");
    a_ref_locked: assert property (locked |=> $stable(REFERENCE_STATE_FIELD))
        else $error("ref written");
    a_ref_write: assert property (test_wr |=> ref8 == ($past(REG_WDATA) & 8'h03))
        else $error("ref test write");
endmodule
bind bppr_bank bppr_bank_assertions chk
(
    .CLK_SYS(CLK_SYS), .RST(RST), .RST_GENERAL(RST_GENERAL), .RST_TURNOFF(RST_TURNOFF),
    .TEST_MODE(TEST_MODE), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RVALID(REG_RVALID),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .CONTROL_BUS_PULLUP_EN(CONTROL_BUS_PULLUP_EN), .SCALING_BUS_PULLUP_EN(SCALING_BUS_PULLUP_EN),
    .POWER_BUTTON_PULLUP_EN(POWER_BUTTON_PULLUP_EN), .SLEEP_PIN_PULLDOWN_EN(SLEEP_PIN_PULLDOWN_EN),
    .HOLD_PIN_PULLDOWN_EN(HOLD_PIN_PULLDOWN_EN), .COLD_RESET_PULLDOWN_EN(COLD_RESET_PULLDOWN_EN),
    .AUX_RESET_OUT_PULLDOWN_EN(AUX_RESET_OUT_PULLDOWN_EN),
    .REFERENCE_STATE_FIELD(REFERENCE_STATE_FIELD)
);

//--- sim/bppr_bank_tb_top.sv
// self-checking bench of the backup and pad pull bank
`timescale 1ns/1ps
module bppr_bank_tb_top;
    logic                   clk_sys = 1'b0;
    logic                   rst = 1'b1, rst_gen = 1'b0, rst_off = 1'b0, test_mode = 1'b0;
    logic                   reg_wr, reg_rd, reg_rvalid;
    logic [7:0]             reg_addr, reg_wdata, reg_rdata, got, lfsr = 8'h26;
    logic [6:0]             pad, pad_exp;
    logic [1:0]             ref_exp;
    logic [7:0]             mirror [3];
    bppr_pkg::bppr_ref_type ref_st;
    int                     miscompares = 0, cmp_count = 0;
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end
    bppr_bank uut
    (
        .CLK_SYS(clk_sys), .RST(rst), .RST_GENERAL(rst_gen), .RST_TURNOFF(rst_off),
        .TEST_MODE(test_mode), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
        .CONTROL_BUS_PULLUP_EN(pad[6]), .SCALING_BUS_PULLUP_EN(pad[5]),
        .POWER_BUTTON_PULLUP_EN(pad[4]), .SLEEP_PIN_PULLDOWN_EN(pad[3]),
        .HOLD_PIN_PULLDOWN_EN(pad[2]), .COLD_RESET_PULLDOWN_EN(pad[1]),
        .AUX_RESET_OUT_PULLDOWN_EN(pad[0]), .REFERENCE_STATE_FIELD(ref_st)
    );
    bppr_host_model host
    (
        .clk(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
    );
    function automatic logic [7:0] next_rand(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a >= 8'h19 && a <= 8'h1b)
            return mirror[a - 8'h19];
        if (a == 8'h1c)
            return {1'b0, pad_exp};
        return (a == 8'h1d) ? {6'h00, ref_exp} : 8'h00;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a);
        host.rd(a, got);
        check("read data", got, exp_rd(a));
    endtask
    task automatic out_chk();
        @(negedge clk_sys);
        check("pad enables", {1'b0, pad}, {1'b0, pad_exp});
        check("ref state", {6'h00, ref_st}, {6'h00, ref_exp});
    endtask
    task automatic rd_all();
        for (int a = 8'h19; a <= 8'h1d; a++)
            rd_chk(a[7:0]);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] a;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        pad_exp = 7'h1f;
        ref_exp = 2'h1;
        mirror = '{8'h00, 8'h00, 8'h00};
        out_chk();
        rd_all();
        repeat (24)
        begin
            lfsr = next_rand(lfsr);
            a = 8'h19 + {6'h00, lfsr[1:0]};
            lfsr = next_rand(lfsr);
            host.wr(a, lfsr);
            if (a == 8'h1c)
                pad_exp = lfsr[6:0];
            else
                mirror[a - 8'h19] = lfsr;
            out_chk();
            rd_chk(a);
        end
        @(posedge clk_sys);
        rst_gen <= 1'b1;
        @(posedge clk_sys);
        rst_gen <= 1'b0;
        pad_exp = 7'h1f;
        out_chk();
        host.wr(8'h1d, 8'hff);
        rd_all();
        test_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int c = 0; c < 4; c++)
        begin
            host.wr(8'h1d, {6'h3f, c[1:0]});
            ref_exp = c[1:0];
            out_chk();
        end
        @(posedge clk_sys);
        test_mode <= 1'b0;
        rst_off <= 1'b1;
        @(posedge clk_sys);
        rst_off <= 1'b0;
        ref_exp = 2'h1;
        out_chk();
        host.wr(8'h20, 8'h5a);
        rd_chk(8'h20);
        rd_all();
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        mirror = '{8'h00, 8'h00, 8'h00};
        rd_all();
        conclude();
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        conclude();
    end
endmodule

//--- sim/bppr_host_model.sv
// firmware side: single register writes and reads
`timescale 1ns/1ps
module bppr_host_model
(
    input  wire logic       clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        // released lines never show the old value
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        d = 'x;
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        // bounded wait: a missing answer stays unknown
        for (int n = 0; n < 4; n++)
        begin
            @(posedge clk);
            if (reg_rvalid === 1'b1)
            begin
                d = reg_rdata;
                break;
            end
        end
    endtask
endmodule
